// ==== hdl/rtc_tod_regs.sv ====
// Overview of operation
// - Hundredths tens digit, BCD 0-9, in bits 7-4 of hundredths register.
// - Hundredths ones digit, BCD 0-9, bits 3-0; register resets to zero.
// - Seconds bit 7 starts the oscillator; cleared stops timekeeping.
// - Seconds tens digit, BCD 0-5, in bits 6-4.
// - Seconds ones digit, BCD 0-9, bits 3-0; register resets to zero.
// - Minutes tens 0-5 in bits 6-4, ones 0-9 in 3-0; bit 7 reads zero.
// - 24-hour mode keeps hour tens as two bits, 5-4.
// - 24-hour tens digit only takes 0, 1 or 2.
// - Hour ones digit, BCD 0-9, in bits 3-0.
// - Hundredths step every 41 ticks, 40 on each 25th step.
// - Day rolls at 23:59:59.99 or 11:59:59.99 PM, carrying to date.
// - Read buffers snapshot counters at read start, when a request has snap set.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_tod_defs.svh"

module rtc_tod_regs
    import rtc_tod_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Time base from the oscillator, 4.096 kHz, one-cycle pulses
    input wire logic tick_4k_i,
    // Register access from the serial engine
    input wire reg_req_t req_i,
    output logic [7:0] rd_data_o,
    // Status and control toward the rest of the clock
    output logic osc_start_o,
    output logic trim_direction_o,
    output logic day_carry_o
);

    tod_state_t st_ff;
    tod_state_t nxt_st;
    logic hsec_pulse;
    logic c_sec;
    logic c_min;
    logic c_hour;
    logic fmt12;
    logic wr_hsec;
    logic wr_sec;
    logic wr_min;
    logic wr_hour;

    // Returns {wrap, next digit}; a digit at or past its top goes to zero
    function automatic logic [4:0] step_digit(input logic [3:0] d, input logic [3:0] top);
        step_digit = (d >= top) ? 5'h10 : {1'b0, d + 4'h1};
    endfunction

    function automatic logic [7:0] reg_byte(input tod_t t, input logic [4:0] a);
        unique case (a)
            `RTC_HSEC_ADDR: reg_byte = t.hsec;
            `RTC_SEC_ADDR: reg_byte = t.sec;
            `RTC_MIN_ADDR: reg_byte = t.min;
            `RTC_HOUR_ADDR: reg_byte = t.hour;
            default: reg_byte = 8'h00;
        endcase
    endfunction

    assign osc_start_o = st_ff.live.sec[`OSC_START_BIT];
    assign trim_direction_o = st_ff.live.hour[`TRIM_DIR_BIT];
    assign fmt12 = st_ff.live.hour[`HOUR_FMT_BIT];
    assign rd_data_o = st_ff.rdata;
    assign day_carry_o = st_ff.day_carry;

    assign wr_hsec = req_i.wr && req_i.addr == `RTC_HSEC_ADDR;
    assign wr_sec = req_i.wr && req_i.addr == `RTC_SEC_ADDR;
    assign wr_min = req_i.wr && req_i.addr == `RTC_MIN_ADDR;
    assign wr_hour = req_i.wr && req_i.addr == `RTC_HOUR_ADDR;

    // Ticks only reach the divider while the oscillator is started
    hsec_tick_gen u_hsec_gen (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .tick_i(tick_4k_i && osc_start_o),
        .pulse_o(hsec_pulse)
    );

    assign c_sec = hsec_pulse && st_ff.live.hsec == 8'h99;
    assign c_min = c_sec && st_ff.live.sec[6:0] == 7'h59;
    assign c_hour = c_min && st_ff.live.min[6:0] == 7'h59;

    always_comb begin
        logic [4:0] s_lo;
        logic [4:0] s_hi;
        logic [3:0] h_tens;
        s_lo = 5'h00;
        s_hi = 5'h00;
        h_tens = 4'h0;
        nxt_st = st_ff;
        nxt_st.day_carry = 1'b0;
        if (hsec_pulse) begin
            s_lo = step_digit(st_ff.live.hsec[3:0], 4'h9);
            s_hi = step_digit(st_ff.live.hsec[7:4], 4'h9);
            nxt_st.live.hsec[3:0] = s_lo[3:0];
            if (s_lo[4]) begin
                nxt_st.live.hsec[7:4] = s_hi[3:0];
            end
        end
        if (c_sec) begin
            s_lo = step_digit(st_ff.live.sec[3:0], 4'h9);
            s_hi = step_digit({1'b0, st_ff.live.sec[6:4]}, 4'h5);
            nxt_st.live.sec[3:0] = s_lo[3:0];
            if (s_lo[4]) begin
                nxt_st.live.sec[6:4] = s_hi[2:0];
            end
        end
        if (c_min) begin
            s_lo = step_digit(st_ff.live.min[3:0], 4'h9);
            s_hi = step_digit({1'b0, st_ff.live.min[6:4]}, 4'h5);
            nxt_st.live.min[3:0] = s_lo[3:0];
            if (s_lo[4]) begin
                nxt_st.live.min[6:4] = s_hi[2:0];
            end
        end
        if (c_hour) begin
            h_tens = fmt12 ? {3'h0, st_ff.live.hour[4]} : {2'h0, st_ff.live.hour[5:4]};
            if (!fmt12) begin
                if (st_ff.live.hour[5:0] == 6'h23) begin
                    nxt_st.live.hour[5:0] = 6'h00;
                    nxt_st.day_carry = 1'b1;
                end else begin
                    s_lo = step_digit(st_ff.live.hour[3:0], 4'h9);
                    nxt_st.live.hour[3:0] = s_lo[3:0];
                    if (s_lo[4]) begin
                        nxt_st.live.hour[5:4] = h_tens[1:0] + 2'h1;
                    end
                end
            end else begin
                if (st_ff.live.hour[4:0] == 5'h12) begin
                    nxt_st.live.hour[4:0] = 5'h01;
                end else if (st_ff.live.hour[4:0] == 5'h11) begin
                    // Noon and midnight both show 12; PM flips on the way in
                    nxt_st.live.hour[4:0] = 5'h12;
                    nxt_st.live.hour[`HOUR_PM_BIT] = !st_ff.live.hour[`HOUR_PM_BIT];
                    nxt_st.day_carry = st_ff.live.hour[`HOUR_PM_BIT];
                end else begin
                    s_lo = step_digit(st_ff.live.hour[3:0], 4'h9);
                    nxt_st.live.hour[3:0] = s_lo[3:0];
                    if (s_lo[4]) begin
                        nxt_st.live.hour[4] = 1'b1;
                    end
                end
            end
        end
        // A write lands over any count step in the same cycle
        if (wr_hsec) begin
            nxt_st.live.hsec = req_i.wdata;
        end
        if (wr_sec) begin
            nxt_st.live.sec = req_i.wdata;
        end
        if (wr_min) begin
            nxt_st.live.min = {1'b0, req_i.wdata[6:0]};
        end
        if (wr_hour) begin
            nxt_st.live.hour = req_i.wdata;
        end
        // Reads without snap come from the frozen copy so a carry mid-burst cannot tear the time
        if (req_i.snap) begin
            nxt_st.snap = st_ff.live;
        end
        if (req_i.rd) begin
            nxt_st.rdata = reg_byte(req_i.snap ? st_ff.live : st_ff.snap, req_i.addr);
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    hsec_ones_wrap_a: assert property (
        hsec_pulse && st_ff.live.hsec[3:0] == 4'h9 && !wr_hsec |=> st_ff.live.hsec[3:0] == 4'h0)
        else $error("Hundredths ones did not wrap to zero");
    hsec_full_wrap_a: assert property (
        c_sec && !wr_hsec |=> st_ff.live.hsec == 8'h00 && $past(st_ff.live.hsec) == 8'h99)
        else $error("Hundredths did not wrap from 99");
    osc_halt_a: assert property (
        !osc_start_o && !wr_hsec |=> $stable(st_ff.live.hsec))
        else $error("Hundredths moved with oscillator stopped");
    sec_wrap_a: assert property (
        c_min && !wr_sec |=> st_ff.live.sec == {$past(st_ff.live.sec[7]), 7'h00})
        else $error("Seconds did not wrap from 59 or lost start bit");
    sec_ones_a: assert property (
        c_sec && !wr_sec && st_ff.live.sec[3:0] != 4'h9
        |=> st_ff.live.sec[3:0] == $past(st_ff.live.sec[3:0]) + 4'h1)
        else $error("Seconds ones did not step by one");
    min_top_bit_a: assert property (st_ff.live.min[7] == 1'b0)
        else $error("Minutes bit 7 not zero");
    hour24_wrap_a: assert property (
        c_hour && !fmt12 && st_ff.live.hour[5:0] == 6'h23 && !wr_hour
        |=> st_ff.live.hour[5:0] == 6'h00 && day_carry_o)
        else $error("24-hour day did not roll to 00 with carry");
    hour24_tens_a: assert property (
        c_hour && !fmt12 && st_ff.live.hour[5:0] == 6'h19 && !wr_hour
        |=> st_ff.live.hour[5:0] == 6'h20)
        else $error("24-hour tens did not step at 19");
    hour12_noon_a: assert property (
        c_hour && fmt12 && st_ff.live.hour[4:0] == 5'h11 && !wr_hour
        |=> st_ff.live.hour[4:0] == 5'h12 && st_ff.live.hour[5] != $past(st_ff.live.hour[5]))
        else $error("12-hour 11 to 12 step did not flip PM");
    hour12_one_a: assert property (
        c_hour && fmt12 && st_ff.live.hour[4:0] == 5'h12 && !wr_hour
        |=> st_ff.live.hour[4:0] == 5'h01 && !day_carry_o)
        else $error("12-hour 12 did not step to 01");
    midnight_carry_a: assert property (
        day_carry_o |-> $past(c_hour) && ($past(fmt12) ? $past(st_ff.live.hour[5:0]) == 6'h31
        : $past(st_ff.live.hour[5:0]) == 6'h23))
        else $error("Day carry without a midnight rollover");
    trim_keep_a: assert property (
        c_hour && !wr_hour |=> st_ff.live.hour[7:6] == $past(st_ff.live.hour[7:6]))
        else $error("Counting changed trim or format bits");
    snap_hold_a: assert property (
        !req_i.snap |=> $stable(st_ff.snap))
        else $error("Read buffer changed without a snapshot");
    snap_take_a: assert property (
        req_i.snap |=> st_ff.snap == $past(st_ff.live))
        else $error("Snapshot did not capture the live time");

    midnight_c: cover property (day_carry_o && !fmt12);
    noon_c: cover property (c_hour && fmt12 && st_ff.live.hour[4:0] == 5'h11);
    burst_read_c: cover property (req_i.snap && req_i.rd ##1 req_i.rd ##1 req_i.rd);

endmodule

`default_nettype wire

// ==== hdl/rtc_tod_defs.svh ====
`ifndef RTC_TOD_DEFS_SVH
`define RTC_TOD_DEFS_SVH

// Register offsets in the clock register space
`define RTC_ADDR_W 5
`define RTC_HSEC_ADDR 5'h00
`define RTC_SEC_ADDR 5'h01
`define RTC_MIN_ADDR 5'h02
`define RTC_HOUR_ADDR 5'h03
`define RTC_TOP_ADDR 5'h1F

// Reset value of every time-of-day register
`define RTC_REG_RESET 8'h00

// Field positions
`define OSC_START_BIT 7
`define MIN_UNUSED_BIT 7
`define TRIM_DIR_BIT 7
`define HOUR_FMT_BIT 6
`define HOUR_PM_BIT 5

// Hundredths generation from the 4.096 kHz tick: 41 ticks x 24, then 40 ticks
`define HSEC_LONG_TICKS 41
`define HSEC_SHORT_TICKS 40
`define HSEC_GROUP_LEN 25

`endif

// ==== hdl/rtc_tod_pkg.sv ====
package rtc_tod_pkg;

    // One access from the serial engine to the clock register space
    typedef struct packed {
        logic wr;
        logic rd;
        logic snap;
        logic [4:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
        logic [7:0] hsec;
    } tod_t;

    typedef struct packed {
        tod_t live;
        tod_t snap;
        logic [7:0] rdata;
        logic day_carry;
    } tod_state_t;

    typedef struct packed {
        logic [5:0] cnt;
        logic [4:0] idx;
    } hsec_gen_state_t;

endpackage

// ==== hdl/hsec_tick_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rtc_tod_defs.svh"

module hsec_tick_gen
    import rtc_tod_pkg::*;
#(
    parameter int LONG_TICKS = `HSEC_LONG_TICKS,
    parameter int SHORT_TICKS = `HSEC_SHORT_TICKS,
    parameter int GROUP_LEN = `HSEC_GROUP_LEN
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Gated 4.096 kHz tick in, hundredths step out
    input wire logic tick_i,
    output logic pulse_o
);

    hsec_gen_state_t st_ff;
    hsec_gen_state_t nxt_st;
    logic last_slot;
    logic [5:0] limit;

    assign last_slot = (st_ff.idx == 5'(GROUP_LEN - 1));
    assign limit = last_slot ? 6'(SHORT_TICKS - 1) : 6'(LONG_TICKS - 1);
    assign pulse_o = tick_i && (st_ff.cnt == limit);

    always_comb begin
        nxt_st = st_ff;
        if (tick_i) begin
            if (pulse_o) begin
                nxt_st.cnt = 6'h0;
                nxt_st.idx = last_slot ? 5'h00 : st_ff.idx + 5'h01;
            end else begin
                nxt_st.cnt = st_ff.cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    short_slot_a: assert property (pulse_o && last_slot |-> st_ff.cnt == 6'h27)
        else $error("Last step of group not after 40 ticks");
    long_slot_a: assert property (pulse_o && !last_slot |-> st_ff.cnt == 6'h28)
        else $error("Regular step not after 41 ticks");
    group_wrap_a: assert property (pulse_o && last_slot |=> st_ff.idx == 5'h00)
        else $error("Group of 25 steps did not restart");

endmodule

`default_nettype wire

// ==== bench/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_model
    import rtc_tod_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Register access toward the device
    output reg_req_t req_o,
    input wire logic [7:0] rd_data_i
);
    initial begin
        req_o = '0;
    end
    // Held for one edge only; data taken one edge later
    task automatic access(input logic wr, input logic rd, input logic snap,
                          input logic [4:0] addr, input logic [7:0] wdata,
                          output logic [7:0] data);
        @(posedge clk_i);
        req_o <= '{wr: wr, rd: rd, snap: snap, addr: addr, wdata: wdata};
        @(posedge clk_i);
        req_o <= '0;
        #1;
        data = rd_data_i;
    endtask
    task automatic write_reg(input logic [4:0] addr, input logic [7:0] wdata);
        logic [7:0] unused;
        access(1'h1, 1'h0, 1'h0, addr, wdata, unused);
    endtask
    // Back-to-back reads of three bytes; only the first reloads the buffer
    task automatic read_burst3(input logic [4:0] addr, output logic [7:0] d0,
                               output logic [7:0] d1, output logic [7:0] d2);
        @(posedge clk_i);
        req_o <= '{wr: 1'h0, rd: 1'h1, snap: 1'h1, addr: addr, wdata: 8'h00};
        @(posedge clk_i);
        req_o <= '{wr: 1'h0, rd: 1'h1, snap: 1'h0, addr: addr + 5'h01, wdata: 8'h00};
        #1;
        d0 = rd_data_i;
        @(posedge clk_i);
        req_o <= '{wr: 1'h0, rd: 1'h1, snap: 1'h0, addr: addr + 5'h02, wdata: 8'h00};
        #1;
        d1 = rd_data_i;
        @(posedge clk_i);
        req_o <= '0;
        #1;
        d2 = rd_data_i;
    endtask
    // A single read is a whole read operation, so it reloads the buffer
    task automatic read_reg(input logic [4:0] addr, output logic [7:0] data);
        access(1'h0, 1'h1, 1'h1, addr, 8'h00, data);
    endtask
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rtc_tod_defs.svh"
module tb;
    import rtc_tod_pkg::*;
    logic clk_i;
    logic reset_i;
    logic tick_4k_i;
    reg_req_t req;
    logic [7:0] rd_data;
    logic osc_start;
    logic trim_direction;
    logic day_carry;
    int failures;
    int comparisons;
    int carries = 0;
    rtc_tod_regs uut (.clk_i(clk_i), .reset_i(reset_i), .tick_4k_i(tick_4k_i),
        .req_i(req), .rd_data_o(rd_data), .osc_start_o(osc_start),
        .trim_direction_o(trim_direction), .day_carry_o(day_carry));
    host_model host (.clk_i(clk_i), .req_o(req), .rd_data_i(rd_data));
    initial begin
        clk_i = 1'h0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (day_carry === 1'h1) begin
            carries <= carries + 1;
        end
    end
    task automatic report_and_stop();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t byte got %h want %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t flag got %b want %b", $time, got, exp);
        end
    endtask
    task automatic expect_reg(input logic [4:0] addr, input logic [7:0] exp);
        logic [7:0] data;
        host.read_reg(addr, data);
        check_byte(data, exp);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk_i);
            tick_4k_i <= 1'h1;
            @(posedge clk_i);
            tick_4k_i <= 1'h0;
        end
    endtask
    task automatic test_reset();
        for (int a = 0; a < 5; a++) begin
            expect_reg(5'(a), 8'h00);
        end
        check_bit(osc_start, 1'h0);
        check_bit(trim_direction, 1'h0);
        $display("test reset done");
    endtask
    task automatic test_regs();
        host.write_reg(`RTC_MIN_ADDR, 8'hD9);
        expect_reg(`RTC_MIN_ADDR, 8'h59);
        host.write_reg(`RTC_HOUR_ADDR, 8'h80);
        check_bit(trim_direction, 1'h1);
        expect_reg(`RTC_HOUR_ADDR, 8'h80);
        host.write_reg(`RTC_HOUR_ADDR, 8'h00);
        check_bit(trim_direction, 1'h0);
        host.write_reg(5'h04, 8'hFF);
        expect_reg(5'h04, 8'h00);
        host.write_reg(`RTC_SEC_ADDR, 8'h80);
        check_bit(osc_start, 1'h1);
        host.write_reg(`RTC_SEC_ADDR, 8'h00);
        check_bit(osc_start, 1'h0);
        $display("test regs done");
    endtask
    task automatic test_stopped();
        host.write_reg(`RTC_HSEC_ADDR, 8'h00);
        ticks(50);
        expect_reg(`RTC_HSEC_ADDR, 8'h00);
        $display("test stopped done");
    endtask
    // One group is 24 steps of 41 ticks and one of 40
    task automatic test_hsec_rate();
        host.write_reg(`RTC_SEC_ADDR, 8'h80);
        ticks(40);
        expect_reg(`RTC_HSEC_ADDR, 8'h00);
        ticks(1);
        expect_reg(`RTC_HSEC_ADDR, 8'h01);
        ticks(983);
        expect_reg(`RTC_HSEC_ADDR, 8'h25);
        $display("test hsec rate done");
    endtask
    task automatic rollover(input logic [7:0] h_in, input logic [7:0] h_out,
                            input int n_carry);
        int base;
        host.write_reg(`RTC_HOUR_ADDR, h_in);
        host.write_reg(`RTC_MIN_ADDR, 8'h59);
        host.write_reg(`RTC_SEC_ADDR, 8'hD9);
        host.write_reg(`RTC_HSEC_ADDR, 8'h99);
        base = carries;
        ticks(41);
        repeat (2) @(posedge clk_i);
        expect_reg(`RTC_HSEC_ADDR, 8'h00);
        expect_reg(`RTC_SEC_ADDR, 8'h80);
        expect_reg(`RTC_MIN_ADDR, 8'h00);
        expect_reg(`RTC_HOUR_ADDR, h_out);
        check_byte(8'(carries - base), 8'(n_carry));
        $display("test rollover %h done", h_in);
    endtask
    // Seconds ones step without a minute carry, read back as one burst
    task automatic test_sec_step();
        logic [7:0] d0;
        logic [7:0] d1;
        logic [7:0] d2;
        host.write_reg(`RTC_MIN_ADDR, 8'h37);
        host.write_reg(`RTC_SEC_ADDR, 8'h84);
        host.write_reg(`RTC_HSEC_ADDR, 8'h99);
        ticks(41);
        host.read_burst3(`RTC_HSEC_ADDR, d0, d1, d2);
        check_byte(d0, 8'h00);
        check_byte(d1, 8'h85);
        check_byte(d2, 8'h37);
        $display("test sec step done");
    endtask
    task automatic test_snapshot();
        logic [7:0] data;
        host.write_reg(`RTC_HSEC_ADDR, 8'h05);
        expect_reg(`RTC_HSEC_ADDR, 8'h05);
        ticks(41);
        host.access(1'h0, 1'h1, 1'h0, `RTC_HSEC_ADDR, 8'h00, data);
        check_byte(data, 8'h05);
        expect_reg(`RTC_HSEC_ADDR, 8'h06);
        $display("test snapshot done");
    endtask
    initial begin
        reset_i = 1'h1;
        tick_4k_i = 1'h0;
        failures = 0;
        comparisons = 0;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'h0;
        test_reset();
        test_regs();
        test_stopped();
        test_hsec_rate();
        rollover(8'h19, 8'h20, 0);
        rollover(8'h23, 8'h00, 1);
        rollover(8'h71, 8'h52, 1);
        rollover(8'h51, 8'h72, 0);
        rollover(8'h09, 8'h10, 0);
        rollover(8'h49, 8'h50, 0);
        rollover(8'h72, 8'h61, 0);
        test_sec_step();
        test_snapshot();
        report_and_stop();
    end
    // Whole run is near 3100 cycles
    initial begin
        #100000;
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
